// *** rtl/tsa_top.sv ***
// Purpose: TDM highway time-slot assigner, transmit and receive sides
// Assumes: Highway pins are asynchronous and much slower than i_mclk
// Notes:   Byte side talks to the framing engine on i_mclk
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module tsa_top
  import tsa_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_frame_sync,
  input  wire logic        i_tx_bit_clock,
  input  wire logic        i_pin21,
  input  wire logic        i_rx_in_primary,
  output logic             o_tx_out_primary,
  output logic             o_tx_out_primary_oe,
  output logic             o_pin17,
  output logic             o_pin17_oe,
  input  wire logic [7:0]  i_tx_byte,
  output logic             o_tx_byte_taken,
  output logic [7:0]       o_rx_byte,
  output logic             o_rx_byte_valid
);
  tsa_cfg_if cfg ();

  tsa_regs u_regs (
    .i_mclk      (i_mclk),
    .i_resetn    (i_resetn),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hwdata    (i_hwdata),
    .i_hready    (i_hready),
    .o_hrdata    (o_hrdata),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .cfg         (cfg.regs)
  );

  // Control fields
  logic first_en, second_en, halve, rx_sel, rx_inv, tx_inv, tlsb, tx_data_invert, hwy, p17sel, p21sel;
  assign first_en  = cfg.tx_slot_ctl[TSA_TX_FIRST_EN];
  assign second_en = cfg.tx_slot_ctl[TSA_TX_SECOND_EN];
  assign halve     = cfg.rx_slot_ctl[TSA_CLK_HALVE];
  assign rx_sel    = cfg.rx_slot_ctl[TSA_RX_SEL];
  assign rx_inv    = cfg.bit_edge_ctl[TSA_RX_INV];
  assign tx_inv    = cfg.bit_edge_ctl[TSA_TX_INV];
  assign tlsb      = cfg.tx_offset_ctl[TSA_TLSB];
  assign tx_data_invert       = cfg.tx_offset_ctl[TSA_TXD_INV];
  assign hwy       = cfg.mode_ctl[TSA_HWY_EN];
  assign p17sel    = cfg.mode_ctl[TSA_P17_SEL];
  assign p21sel    = cfg.mode_ctl[TSA_P21_SEL];

  // Pin synchronisers, third stage only for edge detection
  logic [TSA_NUM_PINS-1:0] pins, s1_q, s2_q, s3_q;
  assign pins = {i_rx_in_primary, i_pin21, i_tx_bit_clock, i_frame_sync};
  genvar gi;
  generate
    for (gi = 0; gi < TSA_NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pins[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
        end
      end
    end
  endgenerate

  function automatic logic edge_of(input logic now, input logic prev, input logic rising);
    edge_of = rising ? (now && !prev) : (!now && prev);
  endfunction

  function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] idx,
                                    input logic lsb_first);
    pick_bit = lsb_first ? b[idx] : b[TSA_BIT_LAST - idx];
  endfunction

  logic fs_pulse, tx_edge_raw, rx_edge_raw, rx_clk_now, rx_clk_prev, tx_edge, rx_edge;
  logic lsb_first, rx_data;
  assign fs_pulse    = s2_q[TSA_PIN_FS] && !s3_q[TSA_PIN_FS];
  assign tx_edge_raw = edge_of(s2_q[TSA_PIN_TXCLK], s3_q[TSA_PIN_TXCLK], tx_inv);
  assign rx_clk_now  = p21sel ? s2_q[TSA_PIN_TXCLK] : s2_q[TSA_PIN_21];
  assign rx_clk_prev = p21sel ? s3_q[TSA_PIN_TXCLK] : s3_q[TSA_PIN_21];
  assign rx_edge_raw = edge_of(rx_clk_now, rx_clk_prev, rx_inv);
  assign lsb_first   = !hwy || tlsb;
  assign rx_data     = rx_sel ? s2_q[TSA_PIN_21] : s2_q[TSA_PIN_RXD];

  // Clock halving: every second edge after sync is dropped, starting with the second
  logic tx_half_q, tx_half_d, rx_half_q, rx_half_d;
  always_comb begin
    tx_half_d = fs_pulse ? 1'b0 : (tx_edge_raw ? !tx_half_q : tx_half_q);
    rx_half_d = fs_pulse ? 1'b0 : (rx_edge_raw ? !rx_half_q : rx_half_q);
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_half_q <= 1'b0;
      rx_half_q <= 1'b0;
    end else begin
      tx_half_q <= tx_half_d;
      rx_half_q <= rx_half_d;
    end
  end
  assign tx_edge = tx_edge_raw && (!halve || !tx_half_q);
  assign rx_edge = rx_edge_raw && (!halve || !rx_half_q);

  logic       tx_hit, rx_hit;
  logic [2:0] tx_bit_idx, rx_bit_idx;

  tsa_slot_timer u_tx_timer (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_frame_start (fs_pulse),
    .i_bit_edge    (tx_edge),
    .i_bit_offset  (cfg.bit_edge_ctl[TSA_TBOF_LSB +: TSA_BOF_W]),
    .i_slot_offset (cfg.tx_offset_ctl[TSA_SLOT_LSB +: TSA_SLOT_W]),
    .i_slot_number (cfg.tx_slot_ctl[TSA_SLOT_LSB +: TSA_SLOT_W]),
    .o_hit         (tx_hit),
    .o_bit_idx     (tx_bit_idx)
  );

  tsa_slot_timer u_rx_timer (
    .i_mclk        (i_mclk),
    .i_resetn      (i_resetn),
    .i_frame_start (fs_pulse),
    .i_bit_edge    (rx_edge),
    .i_bit_offset  (cfg.bit_edge_ctl[TSA_RBOF_LSB +: TSA_BOF_W]),
    .i_slot_offset (TSA_STATUS_PAD),
    .i_slot_number (cfg.rx_slot_ctl[TSA_SLOT_LSB +: TSA_SLOT_W]),
    .o_hit         (rx_hit),
    .o_bit_idx     (rx_bit_idx)
  );

  // Transmit path
  logic [7:0] tx_byte_q, tx_byte_d, cur_byte;
  logic       taken_q, taken_d, prim_q, prim_d, prim_oe_q, prim_oe_d;
  logic       p17_q, p17_d, p17_oe_q, p17_oe_d, tx_slot_q, tx_slot_d, tx_bit_raw;
  assign cur_byte   = (tx_bit_idx == TSA_BIT_FIRST) ? i_tx_byte : tx_byte_q;
  assign tx_bit_raw = pick_bit(cur_byte, tx_bit_idx, lsb_first);
  always_comb begin
    tx_byte_d = tx_byte_q;
    taken_d   = 1'b0;
    prim_d    = prim_q;
    prim_oe_d = prim_oe_q;
    p17_d     = p17_q;
    p17_oe_d  = p17sel ? 1'b1 : p17_oe_q;
    tx_slot_d = tx_slot_q;
    if (tx_edge) begin
      tx_slot_d = tx_hit;
      prim_oe_d = tx_hit && first_en;
      p17_oe_d  = p17sel || (tx_hit && second_en);
      p17_d     = p17sel ? tx_hit : (tx_bit_raw ^ tx_data_invert);
      if (tx_hit) begin
        tx_byte_d = cur_byte;
        taken_d   = (tx_bit_idx == TSA_BIT_FIRST);
        prim_d    = tx_bit_raw ^ tx_data_invert;
      end
    end
    if (p17sel && !hwy) begin
      p17_d = 1'b0;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_byte_q <= 8'h00;
      taken_q   <= 1'b0;
      prim_q    <= 1'b0;
      prim_oe_q <= 1'b0;
      p17_q     <= 1'b0;
      p17_oe_q  <= 1'b0;
      tx_slot_q <= 1'b0;
    end else begin
      tx_byte_q <= tx_byte_d;
      taken_q   <= taken_d;
      prim_q    <= prim_d;
      prim_oe_q <= prim_oe_d;
      p17_q     <= p17_d;
      p17_oe_q  <= p17_oe_d;
      tx_slot_q <= tx_slot_d;
    end
  end

  // Receive path
  logic [7:0] rx_sr_q, rx_sr_d, rx_byte_q, rx_byte_d, rx_next;
  logic       rx_valid_q, rx_valid_d, rx_slot_q, rx_slot_d;
  assign rx_next = lsb_first ? {rx_data, rx_sr_q[7:1]} : {rx_sr_q[6:0], rx_data};
  always_comb begin
    rx_sr_d    = rx_sr_q;
    rx_byte_d  = rx_byte_q;
    rx_valid_d = 1'b0;
    rx_slot_d  = rx_edge ? rx_hit : rx_slot_q;
    if (rx_hit) begin
      rx_sr_d = rx_next;
      if (rx_bit_idx == TSA_BIT_LAST) begin
        rx_byte_d  = rx_next;
        rx_valid_d = 1'b1;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rx_sr_q    <= 8'h00;
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_slot_q  <= 1'b0;
    end else begin
      rx_sr_q    <= rx_sr_d;
      rx_byte_q  <= rx_byte_d;
      rx_valid_q <= rx_valid_d;
      rx_slot_q  <= rx_slot_d;
    end
  end

  assign cfg.status          = {TSA_STATUS_PAD, rx_slot_q, tx_slot_q};
  assign o_tx_out_primary    = prim_q;
  assign o_tx_out_primary_oe = prim_oe_q;
  assign o_pin17             = p17_q;
  assign o_pin17_oe          = p17_oe_q;
  assign o_tx_byte_taken     = taken_q;
  assign o_rx_byte           = rx_byte_q;
  assign o_rx_byte_valid     = rx_valid_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  tx_oe_slot_a: assert property ($rose(o_tx_out_primary_oe) |->
    $past(tx_edge && tx_hit && first_en)) else $error("primary driven outside slot");
  dual_same_a: assert property (o_tx_out_primary_oe && o_pin17_oe && !$past(p17sel)
    |-> o_pin17 == o_tx_out_primary) else $error("pins carry different data");
  strobe_low_a: assert property (p17sel && !hwy |=> !o_pin17)
    else $error("strobe high while highway off");
  p17_override_a: assert property (p17sel |=> o_pin17_oe)
    else $error("strobe pin not driven");
  invert_a: assert property (tx_edge && tx_hit |=>
    o_tx_out_primary == ($past(tx_bit_raw) ^ $past(tx_data_invert))) else $error("bad inversion");
  lsb_default_a: assert property (!hwy && tx_edge && tx_hit && tx_bit_idx == TSA_BIT_FIRST
    |=> o_tx_out_primary == ($past(i_tx_byte[0]) ^ $past(tx_data_invert))) else $error("not lsb first");
  msb_first_a: assert property (hwy && !tlsb && tx_edge && tx_hit
    && tx_bit_idx == TSA_BIT_FIRST |=> o_tx_out_primary == ($past(i_tx_byte[7]) ^ $past(tx_data_invert)))
    else $error("not msb first");
  byte_taken_a: assert property (o_tx_byte_taken |->
    $past(tx_hit && tx_bit_idx == TSA_BIT_FIRST)) else $error("byte taken off slot");
  rx_valid_a: assert property (o_rx_byte_valid |->
    $past(rx_hit && rx_bit_idx == TSA_BIT_LAST)) else $error("byte valid off slot");
  halving_a: assert property (halve && tx_edge_raw && tx_half_q |-> !tx_edge)
    else $error("halving edge not dropped");

  tx_slot_c: cover property (o_tx_byte_taken ##[1:1000] o_tx_byte_taken);
  rx_byte_c: cover property (o_rx_byte_valid);
  dual_pin_c: cover property (o_tx_out_primary_oe && o_pin17_oe && !p17sel);
  strobe_c: cover property (p17sel && o_pin17);
endmodule

// *** rtl/tsa_pkg.sv ***
// Purpose: Shared constants for the TDM time-slot assigner
// Assumes: AHB-Lite word registers at byte offsets below
// Notes:   Pin vector indices and register fields live here
package tsa_pkg;
  localparam int unsigned TSA_REG_W = 8;
  localparam int unsigned TSA_SLOT_W = 6;
  localparam int unsigned TSA_BOF_W = 3;
  localparam int unsigned TSA_POS_W = 9;
  localparam int unsigned TSA_NUM_PINS = 4;

  localparam logic [7:0] TSA_OFF_TX_SLOT = 8'h00;
  localparam logic [7:0] TSA_OFF_RX_SLOT = 8'h04;
  localparam logic [7:0] TSA_OFF_BIT_EDGE = 8'h08;
  localparam logic [7:0] TSA_OFF_TX_OFFSET = 8'h0C;
  localparam logic [7:0] TSA_OFF_MODE = 8'h10;
  localparam logic [7:0] TSA_OFF_STATUS = 8'h14;

  localparam logic [7:0] TSA_RST_TX_SLOT = 8'h00;
  localparam logic [7:0] TSA_RST_RX_SLOT = 8'h00;
  localparam logic [7:0] TSA_RST_BIT_EDGE = 8'h01;
  localparam logic [7:0] TSA_RST_TX_OFFSET = 8'h40;
  localparam logic [7:0] TSA_RST_MODE = 8'h00;

  localparam int unsigned TSA_SLOT_LSB = 0;
  localparam int unsigned TSA_TX_SECOND_EN = 6;
  localparam int unsigned TSA_TX_FIRST_EN = 7;
  localparam int unsigned TSA_CLK_HALVE = 6;
  localparam int unsigned TSA_RX_SEL = 7;
  localparam int unsigned TSA_RX_INV = 0;
  localparam int unsigned TSA_RBOF_LSB = 1;
  localparam int unsigned TSA_TX_INV = 4;
  localparam int unsigned TSA_TBOF_LSB = 5;
  localparam int unsigned TSA_TLSB = 6;
  localparam int unsigned TSA_TXD_INV = 7;
  localparam int unsigned TSA_HWY_EN = 0;
  localparam int unsigned TSA_P17_SEL = 1;
  localparam int unsigned TSA_P21_SEL = 2;

  localparam int unsigned TSA_PIN_FS = 0;
  localparam int unsigned TSA_PIN_TXCLK = 1;
  localparam int unsigned TSA_PIN_21 = 2;
  localparam int unsigned TSA_PIN_RXD = 3;

  localparam logic [2:0] TSA_BIT_FIRST = 3'h0;
  localparam logic [2:0] TSA_BIT_LAST = 3'h7;
  localparam logic [1:0] TSA_HTRANS_NONSEQ = 2'h2;
  localparam logic [5:0] TSA_STATUS_PAD = 6'h00;
endpackage

// *** rtl/tsa_cfg_if.sv ***
// Purpose: Carries register contents to the core and status back
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ps
interface tsa_cfg_if;
  logic [7:0] tx_slot_ctl;
  logic [7:0] rx_slot_ctl;
  logic [7:0] bit_edge_ctl;
  logic [7:0] tx_offset_ctl;
  logic [7:0] mode_ctl;
  logic [7:0] status;
  modport regs (output tx_slot_ctl, rx_slot_ctl, bit_edge_ctl, tx_offset_ctl, mode_ctl,
                input  status);
  modport core (input  tx_slot_ctl, rx_slot_ctl, bit_edge_ctl, tx_offset_ctl, mode_ctl,
                output status);
endinterface

// *** rtl/tsa_slot_timer.sv ***
// Purpose: Bit and slot position counter for one direction
// Assumes: Edge and frame pulses are one cycle, same clock
// Notes:   Silent until the first frame pulse
`timescale 1ns/1ps
module tsa_slot_timer
  import tsa_pkg::*;
(
  input  wire logic                  i_mclk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_frame_start,
  input  wire logic                  i_bit_edge,
  input  wire logic [TSA_BOF_W-1:0]  i_bit_offset,
  input  wire logic [TSA_SLOT_W-1:0] i_slot_offset,
  input  wire logic [TSA_SLOT_W-1:0] i_slot_number,
  output logic                       o_hit,
  output logic [TSA_BOF_W-1:0]       o_bit_idx
);
  logic [TSA_BOF_W-1:0]  skip_q, skip_d;
  logic [TSA_POS_W-1:0]  pos_q, pos_d;
  logic                  run_q, run_d;
  logic [TSA_SLOT_W-1:0] vslot;

  always_comb begin
    skip_d = skip_q;
    pos_d  = pos_q;
    run_d  = run_q;
    if (i_frame_start) begin
      skip_d = i_bit_offset;
      pos_d  = '0;
      run_d  = 1'b1;
    end else if (i_bit_edge && run_q) begin
      if (skip_q != '0) begin
        skip_d = skip_q - 1'b1;
      end else begin
        pos_d = pos_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      skip_q <= '0;
      pos_q  <= '0;
      run_q  <= 1'b0;
    end else begin
      skip_q <= skip_d;
      pos_q  <= pos_d;
      run_q  <= run_d;
    end
  end

  // Virtual slot number counted from the programmed offset
  assign vslot = pos_q[TSA_POS_W-1:TSA_BOF_W] - i_slot_offset;
  assign o_hit = run_q && i_bit_edge && !i_frame_start && (skip_q == '0)
                 && (vslot == i_slot_number);
  assign o_bit_idx = pos_q[TSA_BOF_W-1:0];

  fs_restart_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    i_frame_start |=> (pos_q == '0) && (skip_q == $past(i_bit_offset)))
    else $error("counters not restarted at frame sync");
  offset_skip_a: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    o_hit |-> (skip_q == '0))
    else $error("slot hit during bit offset");
endmodule

// *** rtl/tsa_regs.sv ***
// Purpose: AHB-Lite slave holding the slot assigner registers
// Assumes: Single word transfers, zero wait states
// Notes:   Unmapped reads return zero, writes ignored
`timescale 1ns/1ps
module tsa_regs
  import tsa_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  tsa_cfg_if.regs          cfg
);
  logic [7:0]  tx_slot_q, tx_slot_d, rx_slot_q, rx_slot_d;
  logic [7:0]  bit_edge_q, bit_edge_d, tx_off_q, tx_off_d, mode_q, mode_d;
  logic        wr_q, wr_d;
  logic [7:0]  wa_q, wa_d;
  logic [31:0] rdata_q, rdata_d;
  logic        take;

  assign take = i_hsel && i_htrans[1] && i_hready;

  always_comb begin
    tx_slot_d  = tx_slot_q;
    rx_slot_d  = rx_slot_q;
    bit_edge_d = bit_edge_q;
    tx_off_d   = tx_off_q;
    mode_d     = mode_q;
    wr_d       = take && i_hwrite;
    wa_d       = take ? i_haddr[7:0] : wa_q;
    rdata_d    = rdata_q;
    if (wr_q) begin
      case (wa_q)
        TSA_OFF_TX_SLOT:   tx_slot_d  = i_hwdata[7:0];
        TSA_OFF_RX_SLOT:   rx_slot_d  = i_hwdata[7:0];
        TSA_OFF_BIT_EDGE:  bit_edge_d = i_hwdata[7:0];
        TSA_OFF_TX_OFFSET: tx_off_d   = i_hwdata[7:0];
        TSA_OFF_MODE:      mode_d     = i_hwdata[7:0];
        default:           mode_d     = mode_q;
      endcase
    end
    if (take && !i_hwrite) begin
      case (i_haddr[7:0])
        TSA_OFF_TX_SLOT:   rdata_d = {24'h000000, tx_slot_q};
        TSA_OFF_RX_SLOT:   rdata_d = {24'h000000, rx_slot_q};
        TSA_OFF_BIT_EDGE:  rdata_d = {24'h000000, bit_edge_q};
        TSA_OFF_TX_OFFSET: rdata_d = {24'h000000, tx_off_q};
        TSA_OFF_MODE:      rdata_d = {24'h000000, mode_q};
        TSA_OFF_STATUS:    rdata_d = {24'h000000, cfg.status};
        default:           rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      tx_slot_q  <= TSA_RST_TX_SLOT;
      rx_slot_q  <= TSA_RST_RX_SLOT;
      bit_edge_q <= TSA_RST_BIT_EDGE;
      tx_off_q   <= TSA_RST_TX_OFFSET;
      mode_q     <= TSA_RST_MODE;
      wr_q       <= 1'b0;
      wa_q       <= 8'h00;
      rdata_q    <= 32'h00000000;
    end else begin
      tx_slot_q  <= tx_slot_d;
      rx_slot_q  <= rx_slot_d;
      bit_edge_q <= bit_edge_d;
      tx_off_q   <= tx_off_d;
      mode_q     <= mode_d;
      wr_q       <= wr_d;
      wa_q       <= wa_d;
      rdata_q    <= rdata_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  assign o_hrdata          = rdata_q;
  assign cfg.tx_slot_ctl   = tx_slot_q;
  assign cfg.rx_slot_ctl   = rx_slot_q;
  assign cfg.bit_edge_ctl  = bit_edge_q;
  assign cfg.tx_offset_ctl = tx_off_q;
  assign cfg.mode_ctl      = mode_q;
endmodule

// *** verif/tsa_hwy_model.sv ***
// Purpose: Behavioural TDM highway far side for the slot assigner
// Assumes: Free-running bit clock, frame sync on the first rising edge
// Notes:   Samples transmit pins on the edge opposite to launch
`timescale 1ns/1ps
module tsa_hwy_model #(
  parameter int HALF = 80,
  parameter int BITS = 48
) (
  input  wire logic        i_alt,
  input  wire logic        i_tx_inv,
  input  wire logic        i_a,
  input  wire logic        i_a_oe,
  input  wire logic        i_b,
  input  wire logic        i_b_oe,
  output logic             o_fs,
  output logic             o_clk,
  output logic             o_pin21,
  output logic             o_rxd,
  output logic             o_frm,
  output logic [7:0]       o_byte_a,
  output logic [7:0]       o_byte_b,
  output logic [8:0]       o_pos,
  output logic [8:0]       o_n_a,
  output logic [8:0]       o_ones_b
);
  logic [7:0] sh_a;
  logic [7:0] sh_b;
  logic [7:0] pat;
  logic [8:0] e;
  logic [8:0] n_a;
  logic [8:0] ones_b;
  logic [8:0] pos_a;
  int         p;
  // Pin 21 is the receive clock or, when selected, inverted data
  assign o_pin21 = i_alt ? ~o_rxd : o_clk;
  initial begin
    {o_fs, o_clk, o_rxd, o_frm} = 4'h0;
    {sh_a, sh_b, e, n_a, ones_b, pos_a} = '0;
    forever begin
      for (p = 0; p < BITS; p++) begin
        if (p == 0) begin
          {o_byte_a, o_byte_b, o_pos, o_n_a, o_ones_b} = {sh_a, sh_b, pos_a, n_a, ones_b};
          {e, n_a, ones_b} = '0;
          o_frm = ~o_frm;
        end
        o_fs = (p == 0);
        o_clk = 1'b1;
        #(HALF / 2);
        pat = 8'h30 + 8'(p / 8);
        o_rxd = pat[p % 8];
        #(HALF / 2);
        o_clk = 1'b0;
        #HALF;
      end
    end
  end
  // Stable window covers both latch edges of each receive bit
  always @(o_clk) begin
    if (o_clk !== i_tx_inv) begin
      if (i_a_oe === 1'b1) begin
        if (n_a == 9'h000) pos_a = e;
        sh_a = {i_a, sh_a[7:1]};
        n_a = n_a + 9'h001;
      end
      if (i_b_oe === 1'b1) begin
        sh_b = {i_b, sh_b[7:1]};
        ones_b = ones_b + {8'h00, i_b};
      end
      e = e + 9'h001;
    end
  end
endmodule

// *** verif/test_tsa_top.sv ***
// Purpose: Self-checking bench for the slot assigner over AHB-Lite
// Assumes: Highway model frame of six slots
// Notes:   Positions count sampling edges from frame sync
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_tsa_top;
  import tsa_pkg::*;
  logic        i_mclk, i_resetn, hsel, hwrite, hready, hresp, alt, tinv, frm, t;
  logic        fs, tclk, p21, rxd, da, da_oe, p17, p17_oe, rxv, tkn;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  rxb, ba, bb, txb;
  logic [8:0]  pos, na, onesb;
  int          n_errors, total_checks, cnt, ntk;
  tsa_top dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_frame_sync(fs), .i_tx_bit_clock(tclk), .i_pin21(p21), .i_rx_in_primary(rxd),
    .o_tx_out_primary(da), .o_tx_out_primary_oe(da_oe), .o_pin17(p17),
    .o_pin17_oe(p17_oe), .i_tx_byte(txb), .o_tx_byte_taken(tkn), .o_rx_byte(rxb),
    .o_rx_byte_valid(rxv));
  tsa_hwy_model hwy (.i_alt(alt), .i_tx_inv(tinv), .i_a(da), .i_a_oe(da_oe), .i_b(p17),
    .i_b_oe(p17_oe), .o_fs(fs), .o_clk(tclk), .o_pin21(p21), .o_rxd(rxd), .o_frm(frm),
    .o_byte_a(ba), .o_byte_b(bb), .o_pos(pos), .o_n_a(na), .o_ones_b(onesb));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // Counts byte-taken pulses seen by the framing side
  always @(posedge i_mclk) begin
    if (tkn === 1'b1) ntk++;
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    hsel <= 1'b1;
    htrans <= TSA_HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge i_mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge i_mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rr(input logic [7:0] a, input logic [7:0] e);
    ahb(1'b0, a, 8'h00);
    `CHK("register", {24'h000000, e}, rd)
    `CHK("response", 1'b0, hresp)
  endtask
  task automatic frames(input int n);
    repeat (n) begin
      t = frm;
      cnt = 0;
      while (frm === t && cnt < 3000) begin
        @(negedge i_mclk);
        cnt++;
      end
      if (cnt >= 3000) n_errors++;
    end
  endtask
  task automatic tx(input logic [7:0] e, input logic [8:0] ep, input logic [8:0] en);
    frames(1);
    ntk = 0;
    frames(1);
    `CHK("tx byte", e, ba)
    `CHK("tx start", ep, pos)
    `CHK("tx bits", en, na)
    `CHK("tx taken", 1, ntk)
  endtask
  task automatic rx(input logic [7:0] e);
    frames(1);
    cnt = 0;
    while (rxv !== 1'b1 && cnt < 2000) begin
      @(negedge i_mclk);
      cnt++;
    end
    if (cnt >= 2000) n_errors++;
    `CHK("rx byte", e, rxb)
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  initial begin
    {i_resetn, hsel, hwrite, alt, tinv, htrans, haddr, hwdata} = '0;
    n_errors = 0;
    total_checks = 0;
    ntk = 0;
    txb = 8'h1E;
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    rr(TSA_OFF_TX_SLOT, TSA_RST_TX_SLOT);
    rr(TSA_OFF_RX_SLOT, TSA_RST_RX_SLOT);
    rr(TSA_OFF_BIT_EDGE, TSA_RST_BIT_EDGE);
    rr(TSA_OFF_TX_OFFSET, TSA_RST_TX_OFFSET);
    rr(TSA_OFF_MODE, TSA_RST_MODE);
    wr(8'h18, 8'hFF);
    rr(8'h18, 8'h00);
    wr(TSA_OFF_TX_SLOT, 8'h81);
    tx(8'h1E, 9'd9, 9'd8);
    @(posedge i_mclk) txb <= 8'h5A;
    tx(8'h5A, 9'd9, 9'd8);
    @(posedge i_mclk) txb <= 8'h1E;
    wr(TSA_OFF_TX_SLOT, 8'h82);
    tx(8'h1E, 9'd17, 9'd8);
    wr(TSA_OFF_TX_OFFSET, 8'h41);
    tx(8'h1E, 9'd25, 9'd8);
    wr(TSA_OFF_TX_OFFSET, 8'h40);
    wr(TSA_OFF_BIT_EDGE, 8'h61);
    tx(8'h1E, 9'd20, 9'd8);
    wr(TSA_OFF_BIT_EDGE, 8'h11);
    tinv <= 1'b1;
    tx(8'h1E, 9'd17, 9'd8);
    wr(TSA_OFF_BIT_EDGE, 8'h01);
    tinv <= 1'b0;
    wr(TSA_OFF_TX_SLOT, 8'hC2);
    tx(8'h1E, 9'd17, 9'd8);
    `CHK("second pin", 8'h1E, bb)
    wr(TSA_OFF_MODE, 8'h01);
    wr(TSA_OFF_TX_OFFSET, 8'h00);
    tx(8'h78, 9'd17, 9'd8);
    wr(TSA_OFF_TX_OFFSET, 8'h80);
    tx(8'h87, 9'd17, 9'd8);
    wr(TSA_OFF_MODE, 8'h03);
    tx(8'h87, 9'd17, 9'd8);
    `CHK("strobe", 9'd8, onesb)
    wr(TSA_OFF_MODE, 8'h02);
    tx(8'hE1, 9'd17, 9'd8);
    `CHK("strobe off", 9'd0, onesb)
    wr(TSA_OFF_MODE, 8'h00);
    wr(TSA_OFF_TX_OFFSET, 8'h40);
    wr(TSA_OFF_RX_SLOT, 8'h40);
    wr(TSA_OFF_TX_SLOT, 8'h81);
    tx(8'h03, 9'd17, 9'd16);
    wr(TSA_OFF_RX_SLOT, 8'h03);
    rx(8'h33);
    wr(TSA_OFF_BIT_EDGE, 8'h00);
    rx(8'h33);
    wr(TSA_OFF_BIT_EDGE, 8'h03);
    rx(8'h19);
    wr(TSA_OFF_BIT_EDGE, 8'h01);
    wr(TSA_OFF_MODE, 8'h04);
    wr(TSA_OFF_RX_SLOT, 8'h83);
    alt <= 1'b1;
    rx(8'hCC);
    print_verdict();
  end
endmodule
